//--- rtl/dprl_pkg.sv
// Constants, types and helpers shared by the debug port response logic
package dprl_pkg;

  // ****************************************************************
  // Debug port register addresses (header address bits A[3:2])
  // ****************************************************************
  localparam logic [1:0] DPRL_A_IDENT  = 2'h0;
  localparam logic [1:0] DPRL_A_CTRL   = 2'h1;
  localparam logic [1:0] DPRL_A_SELECT = 2'h2;
  localparam logic [1:0] DPRL_A_RDBUF  = 2'h3;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned CS_ORUNDET    = 0;
  localparam int unsigned CS_TRANSFER_MODE_FIELD_LO = 2;
  localparam int unsigned CS_TRANSACTION_COUNTER_LO  = 12;
  localparam int unsigned AB_DAPABORT   = 0;
  localparam int unsigned AB_STKCMPCLR  = 1;
  localparam int unsigned AB_STKERRCLR  = 2;
  localparam int unsigned AB_WDERRCLR   = 3;
  localparam int unsigned AB_ORUNCLR    = 4;
  localparam int unsigned DL_TURN_LO    = 8;
  localparam int unsigned SEL_CTRLSEL   = 0;
  localparam int unsigned SEL_BANK_LO   = 4;
  localparam int unsigned SEL_APSEL_LO  = 24;

  // ****************************************************************
  // Fixed values
  // ****************************************************************
  localparam logic [1:0]  DL_RSVD_HI        = 2'h1;
  localparam logic [1:0]  TRANSFER_MODE_FIELD_NORMAL    = 2'h0;
  localparam logic [3:0]  DPRL_ARCH_VERSION = 4'h2;
  // Arbitrary identification value; version field is spliced in
  localparam logic [31:0] DPRL_PORT_ID      = 32'h0a5a_0001;
  localparam logic [2:0]  ACK_OK            = 3'h1;
  localparam logic [2:0]  ACK_WAIT          = 3'h2;
  localparam logic [2:0]  ACK_FAULT         = 3'h4;

  // ****************************************************************
  // Cycle counts on the link, in link clock edges
  // ****************************************************************
  localparam logic [5:0] LINE_RESET_ONES = 6'h32;
  localparam logic [5:0] HDR_LAST        = 6'h06;
  localparam logic [5:0] ACK_LAST        = 6'h03;
  localparam logic [5:0] DATA_LAST       = 6'h20;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [31:0] WORD_RESET    = 32'h0000_0000;
  localparam logic [11:0] TRANSACTION_COUNTER_RESET  = 12'h000;
  localparam logic [1:0]  DL_TURN_RESET = 2'h0;
  localparam logic [7:0]  APSEL_RESET   = 8'h00;
  localparam logic [3:0]  BANK_RESET    = 4'h0;
  localparam logic [5:0]  CNT_RESET     = 6'h00;

  // ****************************************************************
  // Types and helpers
  // ****************************************************************
  typedef enum logic [2:0] {
    LK_LOCK, LK_IDLE, LK_HDR, LK_TRN, LK_ACK, LK_RDATA, LK_WDATA
  } dprl_link_t;

  function automatic logic dprl_parity(input logic [31:0] v);
    return ^v;
  endfunction : dprl_parity

endpackage : dprl_pkg

//--- rtl/dprl_link_sampler.sv
// Link clock and data synchroniser with rising edge detection
module dprl_link_sampler
  import dprl_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic link_clk,
  input  wire logic link_dat,
  output logic      rise,
  output logic      dat
);

  typedef struct packed {
    logic clk_s1;
    logic clk_s2;
    logic clk_s3;
    logic dat_s1;
    logic dat_s2;
  } dprl_samp_t;

  dprl_samp_t q;
  dprl_samp_t n;

  // ****************************************************************
  // Two-stage synchronisers; data feeds logic from stage two, the clock from stages two and three
  // ****************************************************************
  always_comb begin
    n        = q;
    n.clk_s1 = link_clk;
    n.clk_s2 = q.clk_s1;
    n.clk_s3 = q.clk_s2;
    n.dat_s1 = link_dat;
    n.dat_s2 = q.dat_s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // Data changes on the far falling edge, so it is stable at our rise
  assign rise = q.clk_s2 && !q.clk_s3;
  assign dat  = q.dat_s2;

endmodule : dprl_link_sampler

//--- rtl/dprl_port.sv
// Serial debug port: packet handling, responses, sticky flags, posted reads
module dprl_port
  import dprl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        link_clk,
  input  wire logic        link_dat_in,
  output logic             link_dat_out,
  output logic             link_dat_oe,
  output logic             ap_req,
  output logic             ap_write,
  output logic [7:0]       ap_sel,
  output logic [7:0]       ap_addr,
  output logic [31:0]      ap_wdata,
  output logic             ap_abort,
  output logic [1:0]       ap_trn_mode,
  output logic [11:0]      ap_trn_count,
  input  wire logic        ap_done,
  input  wire logic [31:0] ap_rdata,
  input  wire logic        ap_err,
  input  wire logic        ap_cmp_fail,
  input  wire logic        ap_present
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    dprl_link_t  st;
    logic [5:0]  cnt;
    logic [5:0]  ones;
    logic [6:0]  hdr;
    logic [2:0]  ack;
    logic [32:0] sh;
    logic        io_out;
    logic        io_oe;
    logic        orundet;
    logic        stk_orun;
    logic        stk_cmp;
    logic        stk_err;
    logic        wd_err;
    logic [1:0]  transfer_mode_field;
    logic [11:0] transaction_counter;
    logic [1:0]  dl_turn;
    logic        ctrlsel;
    logic [3:0]  apbank;
    logic [7:0]  apsel;
    logic [31:0] rdbuf;
    logic [31:0] last_rd;
    logic        ap_busy;
    logic        rd_pend;
    logic        ap_req;
    logic        ap_write;
    logic        ap_abort;
    logic [7:0]  ap_addr;
    logic [31:0] ap_wdata;
  } dprl_core_t;

  dprl_core_t  q;
  dprl_core_t  n;
  logic        lk_rise;
  logic        lk_dat;
  logic [6:0]  h;
  logic        hdr_edge;
  logic        hdr_bad;
  logic        hdr_ok;
  logic        is_ap;
  logic        is_rd;
  logic [1:0]  ra;
  logic        sticky_any;
  logic        needs_ap;
  logic        faultable;
  logic        exempt;
  logic [2:0]  ack_c;
  logic [31:0] cs_val;
  logic [31:0] dl_val;
  logic [31:0] rd_val;
  logic [32:0] wfull;

  // ****************************************************************
  // Link sampling
  // ****************************************************************
  // Synchronous sampling only
  dprl_link_sampler u_samp (
    .clk      (clk),
    .rst_n    (rst_n),
    .link_clk (link_clk),
    .link_dat (link_dat_in),
    .rise     (lk_rise),
    .dat      (lk_dat)
  );

  // ****************************************************************
  // Header decode and response choice
  // ****************************************************************
  assign h        = {lk_dat, q.hdr[6:1]};
  assign hdr_edge = lk_rise && (q.st == LK_HDR) && (q.cnt == HDR_LAST);
  // Stray ones fail the stop bit
  assign hdr_bad  = (dprl_parity({28'h0000000, h[3:0]}) != h[4]) || h[5] || !h[6];
  assign hdr_ok   = hdr_edge && !hdr_bad;
  assign is_ap    = h[0];
  assign is_rd    = h[1];
  assign ra       = h[3:2];
  assign sticky_any = q.stk_orun || q.stk_cmp || q.stk_err || q.wd_err;
  // Link control read needs the port
  assign needs_ap = is_ap || (is_rd && (ra == DPRL_A_RDBUF)) ||
                    (is_rd && (ra == DPRL_A_CTRL) && q.ctrlsel &&
                     (DPRL_ARCH_VERSION >= 4'h2));
  assign faultable = is_ap || ((ra == DPRL_A_CTRL) && (!is_rd || q.ctrlsel)) ||
                     (is_rd && (ra == DPRL_A_RDBUF));
  assign exempt   = !is_ap && ((ra == DPRL_A_IDENT) ||
                    (is_rd && (ra == DPRL_A_CTRL) && !q.ctrlsel));
  assign cs_val   = {8'h00, q.transaction_counter, 4'h0, q.wd_err, 1'b0, q.stk_err, q.stk_cmp,
                     q.transfer_mode_field, q.stk_orun, q.orundet};
  assign dl_val   = {22'h000000, q.dl_turn, DL_RSVD_HI, 3'h0, 3'h0};
  assign wfull    = {lk_dat, q.sh[32:1]};

  // Serial port only; no scan-chain responses
  always_comb begin
    ack_c = ACK_OK;
    // With overrun detection on, first busy hit waits, later ones fault; otherwise all wait
    if (needs_ap && q.ap_busy) begin
      ack_c = (q.orundet && q.stk_orun) ? ACK_FAULT : ACK_WAIT;
    end else if (faultable && !exempt && sticky_any) begin
      ack_c = ACK_FAULT;
    end
  end

  always_comb begin
    rd_val = q.rdbuf;
    if (!is_ap) begin
      if (ra == DPRL_A_IDENT) begin
        rd_val = {DPRL_PORT_ID[31:16], DPRL_ARCH_VERSION, DPRL_PORT_ID[11:0]};
      end else if (ra == DPRL_A_CTRL) begin
        rd_val = q.ctrlsel ? dl_val : cs_val;
      end else if (ra == DPRL_A_SELECT) begin
        rd_val = q.last_rd;
      end
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    n          = q;
    n.ap_req   = 1'b0;
    n.ap_abort = 1'b0;
    // Run of ones is counted whenever the host owns the line
    if (lk_rise && !q.io_oe) begin
      n.ones = !lk_dat ? CNT_RESET :
               (q.ones == LINE_RESET_ONES) ? q.ones : q.ones + 6'h01;
    end
    // Bits move only on a detected rising edge
    if (lk_rise) begin
      case (q.st)
        LK_LOCK: begin
          // Stay silent until a line reset
          if (!lk_dat && (q.ones == LINE_RESET_ONES)) begin
            n.st = LK_IDLE;
          end
        end
        LK_IDLE: begin
          if (lk_dat) begin
            n.st  = LK_HDR;
            n.cnt = CNT_RESET;
          end
        end
        LK_HDR: begin
          n.hdr = h;
          n.cnt = q.cnt + 6'h01;
          if (q.cnt == HDR_LAST) begin
            if (hdr_bad) begin
              n.st = LK_LOCK;
              if (q.orundet) begin
                n.stk_orun = 1'b1;
              end
            end else begin
              n.st  = LK_TRN;
              n.ack = ack_c;
              if (q.orundet && (ack_c != ACK_OK)) begin
                n.stk_orun = 1'b1;
              end
              if (ack_c == ACK_OK) begin
                if (is_rd) begin
                  n.sh      = {dprl_parity(rd_val), rd_val};
                  n.last_rd = rd_val;
                  if (is_ap) begin
                    if (ap_present) begin
                      n.ap_req   = 1'b1;
                      n.ap_write = 1'b0;
                      n.ap_addr  = {q.apbank, ra, 2'h0};
                      n.ap_busy  = 1'b1;
                      n.rd_pend  = 1'b1;
                    end else begin
                      n.rdbuf = WORD_RESET;
                    end
                  end
                end else begin
                  n.rdbuf   = WORD_RESET;
                  n.rd_pend = 1'b0;
                end
              end
            end
          end
        end
        LK_TRN: begin
          n.io_oe  = 1'b1;
          n.io_out = q.ack[0];
          n.cnt    = 6'h01;
          n.st     = LK_ACK;
        end
        LK_ACK: begin
          if (q.cnt != ACK_LAST) begin
            n.io_out = q.ack[q.cnt[1:0]];
            n.cnt    = q.cnt + 6'h01;
          end else if ((q.ack == ACK_OK) && q.hdr[1]) begin
            n.io_out = q.sh[0];
            n.sh     = {1'b0, q.sh[32:1]};
            n.cnt    = CNT_RESET;
            n.st     = LK_RDATA;
          end else begin
            n.io_oe = 1'b0;
            n.cnt   = CNT_RESET;
            n.st    = (q.ack == ACK_OK) ? LK_WDATA : LK_IDLE;
          end
        end
        LK_RDATA: begin
          if (q.cnt == DATA_LAST) begin
            n.io_oe = 1'b0;
            n.st    = LK_IDLE;
          end else begin
            n.io_out = q.sh[0];
            n.sh     = {1'b0, q.sh[32:1]};
            n.cnt    = q.cnt + 6'h01;
          end
        end
        LK_WDATA: begin
          n.sh  = wfull;
          n.cnt = q.cnt + 6'h01;
          if (q.cnt == DATA_LAST) begin
            n.st = LK_IDLE;
            if (dprl_parity(wfull[31:0]) != wfull[32]) begin
              n.wd_err = 1'b1;
            end else if (q.hdr[0]) begin
              // Writes to a missing port are ignored
              if (ap_present) begin
                n.ap_req   = 1'b1;
                n.ap_write = 1'b1;
                n.ap_addr  = {q.apbank, q.hdr[3:2], 2'h0};
                n.ap_wdata = wfull[31:0];
                n.ap_busy  = 1'b1;
              end
            end else if (q.hdr[3:2] == DPRL_A_IDENT) begin
              n.ap_abort = wfull[AB_DAPABORT];
              if (wfull[AB_DAPABORT]) begin
                n.ap_busy = 1'b0;
                n.rd_pend = 1'b0;
              end
              n.stk_cmp  = q.stk_cmp && !wfull[AB_STKCMPCLR];
              n.stk_err  = q.stk_err && !wfull[AB_STKERRCLR];
              n.wd_err   = q.wd_err && !wfull[AB_WDERRCLR];
              n.stk_orun = q.stk_orun && !wfull[AB_ORUNCLR];
            end else if (q.hdr[3:2] == DPRL_A_CTRL) begin
              if (q.ctrlsel) begin
                n.dl_turn = wfull[DL_TURN_LO +: 2];
              end else begin
                n.orundet = wfull[CS_ORUNDET];
                n.transfer_mode_field = wfull[CS_TRANSFER_MODE_FIELD_LO +: 2];
                n.transaction_counter  = wfull[CS_TRANSACTION_COUNTER_LO +: 12];
              end
            end else if (q.hdr[3:2] == DPRL_A_SELECT) begin
              n.ctrlsel = wfull[SEL_CTRLSEL];
              n.apbank  = wfull[SEL_BANK_LO +: 4];
              n.apsel   = wfull[SEL_APSEL_LO +: 8];
            end
          end
        end
        default: begin
          n.st = LK_LOCK;
        end
      endcase
    end
    // Completion handled after clears so a same-cycle set wins
    if (ap_done && q.ap_busy) begin
      n.ap_busy = 1'b0;
      n.rd_pend = 1'b0;
      if (q.rd_pend) begin
        n.rdbuf = ap_rdata;
      end
      if (ap_err) begin
        n.stk_err = 1'b1;
      end
      // Compare flag is set only outside normal mode
      if (ap_cmp_fail && (q.transfer_mode_field != TRANSFER_MODE_FIELD_NORMAL)) begin
        n.stk_cmp = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q    <= '0;
      q.st <= LK_LOCK;
    end else begin
      q <= n;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign link_dat_out = q.io_out;
  assign link_dat_oe  = q.io_oe;
  assign ap_req       = q.ap_req;
  assign ap_write     = q.ap_write;
  assign ap_sel       = q.apsel;
  assign ap_addr      = q.ap_addr;
  assign ap_wdata     = q.ap_wdata;
  assign ap_abort     = q.ap_abort;
  // Count handed to the port, which may treat accesses as undefined
  assign ap_trn_mode  = q.transfer_mode_field;
  assign ap_trn_count = q.transaction_counter;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_bad_hdr;
    hdr_edge && hdr_bad;
  endsequence
  sequence s_lock_quiet;
    (q.st == LK_LOCK) && !q.io_oe;
  endsequence
  sequence s_busy_hit;
    hdr_ok && needs_ap && q.ap_busy && q.orundet;
  endsequence

  a_data_link_control_pattern: assert property (
    (hdr_ok && is_rd && !is_ap && (ra == DPRL_A_CTRL) && q.ctrlsel && (ack_c == ACK_OK))
    |=> (q.sh[7:6] == DL_RSVD_HI) && (q.sh[2:0] == 3'h0)
  ) else $error("link control reserved bits wrong");
  a_orun_nonok: assert property (
    (hdr_ok && q.orundet && (ack_c != ACK_OK)) |=> q.stk_orun
  ) else $error("overrun flag not set on non-OK response");
  a_first_wait: assert property (
    (s_busy_hit ##0 !q.stk_orun) |=> (q.ack == ACK_WAIT) && q.stk_orun
  ) else $error("first busy access not answered WAIT");
  a_then_fault: assert property (
    (s_busy_hit ##0 q.stk_orun) |=> (q.ack == ACK_FAULT)
  ) else $error("later busy access not answered FAULT");
  a_proto_lock: assert property (
    s_bad_hdr |=> s_lock_quiet
  ) else $error("bad header not treated as protocol error");
  a_proto_orun: assert property (
    (s_bad_hdr ##0 q.orundet) |=> q.stk_orun
  ) else $error("protocol error did not set overrun flag");
  a_line_reset: assert property (
    (lk_rise && (q.st == LK_LOCK) && !lk_dat && (q.ones == LINE_RESET_ONES))
    |=> (q.st == LK_IDLE)
  ) else $error("line reset not recognised");
  a_ctrl_wfault: assert property (
    (hdr_ok && !is_ap && !is_rd && (ra == DPRL_A_CTRL) && sticky_any && !q.ap_busy)
    |=> (q.ack == ACK_FAULT)
  ) else $error("status write not faulted");
  a_no_fault: assert property (
    (hdr_ok && exempt) |=> (q.ack != ACK_FAULT) && (q.st == LK_TRN)
  ) else $error("exempt access faulted");
  a_data_link_control_wait: assert property (
    (hdr_ok && is_rd && !is_ap && (ra == DPRL_A_CTRL) && q.ctrlsel && q.ap_busy &&
     !q.orundet) |=> (q.ack == ACK_WAIT)
  ) else $error("link control read not WAIT while busy");
  a_post_keep: assert property (
    (hdr_ok && is_rd && !is_ap && !q.ap_busy) |=> (q.rdbuf == $past(q.rdbuf))
  ) else $error("debug port read disturbed posted result");

endmodule : dprl_port

//--- bench/dprl_host.sv
// Debugger host model that drives the serial link
module dprl_host
  import dprl_pkg::*;
(
  output logic      link_clk,
  output logic      host_oe,
  output logic      host_val,
  input  wire logic line
);
  timeunit 1ns;
  timeprecision 1ns;
  // Eight system clocks per half period, so the three clock synchroniser keeps up
  localparam int HALF = 320;

  initial begin
    link_clk = 1'b0;
    host_oe  = 1'b1;
    host_val = 1'b0;
  end

  // ****************************************************************
  // Bit level
  // ****************************************************************
  // Clocked link only
  task automatic bit_cyc(input logic drv, input logic v, output logic s);
    host_oe  = drv;
    host_val = v;
    #HALF s = line;
    link_clk = 1'b1;
    #HALF link_clk = 1'b0;
  endtask : bit_cyc

  task automatic line_reset();
    logic s;
    repeat (56) bit_cyc(1'b1, 1'b1, s);
    repeat (4) bit_cyc(1'b1, 1'b0, s);
  endtask : line_reset

  // ****************************************************************
  // Packet
  // ****************************************************************
  task automatic xfer(input logic ap, input logic rd, input logic [1:0] a,
                      input logic [31:0] wd, input logic bad,
                      output logic [2:0] ack, output logic [31:0] rdat, output logic rpar);
    logic [7:0] h;
    logic       s;
    h = {1'b1, 1'b0, (^{ap, rd, a}) ^ bad, a[1], a[0], rd, ap, 1'b1};
    for (int i = 0; i < 8; i++) bit_cyc(1'b1, h[i], s);
    bit_cyc(1'b0, 1'b0, s);
    for (int i = 0; i < 3; i++) bit_cyc(1'b0, 1'b0, ack[i]);
    rdat = '0;
    rpar = 1'b0;
    if (ack === ACK_OK && rd) begin
      for (int i = 0; i < 32; i++) bit_cyc(1'b0, 1'b0, rdat[i]);
      bit_cyc(1'b0, 1'b0, rpar);
    end else if (ack === ACK_OK) begin
      for (int i = 0; i < 32; i++) bit_cyc(1'b1, wd[i], s);
      bit_cyc(1'b1, ^wd, s);
    end
    repeat (2) bit_cyc(1'b1, 1'b0, s);
  endtask : xfer
endmodule : dprl_host

//--- bench/dprl_port_tb.sv
// Self-checking bench for the serial debug port
module dprl_port_tb
  import dprl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DLY = 1;
  logic clk, rst_n, link_clk, link_dat_in, link_dat_out, link_dat_oe, host_oe, host_val;
  logic ap_req, ap_write, ap_abort, ap_done, ap_busy;
  logic [7:0] ap_sel, ap_addr;
  logic [31:0] ap_wdata, ap_rdata, last_rd, rdat;
  logic [1:0] ap_trn_mode;
  logic [11:0] ap_trn_count;
  logic ap_err = 1'b0;
  logic ap_cmp_fail = 1'b0;
  logic ap_present = 1'b1;
  logic [2:0] ack;
  logic rpar;
  int ap_lat, ap_n, errors, checks, n_abort;
  logic [48:0] cap;
  // Pull-up wins only when neither side drives
  assign link_dat_in = link_dat_oe ? link_dat_out : (host_oe ? host_val : 1'b1);

  dprl_port DUT (.clk(clk), .rst_n(rst_n), .link_clk(link_clk), .link_dat_in(link_dat_in),
    .link_dat_out(link_dat_out), .link_dat_oe(link_dat_oe), .ap_req(ap_req),
    .ap_write(ap_write), .ap_sel(ap_sel), .ap_addr(ap_addr), .ap_wdata(ap_wdata),
    .ap_abort(ap_abort), .ap_trn_mode(ap_trn_mode), .ap_trn_count(ap_trn_count),
    .ap_done(ap_done), .ap_rdata(ap_rdata), .ap_err(ap_err), .ap_cmp_fail(ap_cmp_fail),
    .ap_present(ap_present));
  dprl_host host (.link_clk(link_clk), .host_oe(host_oe), .host_val(host_val),
    .line(link_dat_in));

  // ****************************************************************
  // Clock and access-port responder
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    {ap_done, ap_busy, ap_n, errors, checks, ap_lat, n_abort} = '0;
    cap = '0;
    ap_rdata = '0;
    last_rd = '0;
  end
  always @(posedge clk) begin
    #DLY;
    if (ap_req === 1'b1) begin
      ap_busy = 1'b1;
      cap = {ap_write, ap_sel, ap_addr, ap_wdata};
      ap_n++;
      repeat (ap_lat) @(posedge clk);
      #DLY ap_done = 1'b1;
      ap_rdata = 32'hc0de_0000 + ap_n;
      if (ap_write === 1'b0) last_rd = ap_rdata;
      @(posedge clk);
      #DLY ap_done = 1'b0;
      ap_busy = 1'b0;
    end
  end
  // Sampled away from the launching edge
  always @(negedge clk) begin
    if (ap_abort === 1'b1) n_abort++;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic go(input logic ap, input logic rd, input logic [1:0] a,
                    input logic [31:0] wd, input logic [2:0] xa, input logic bad = 1'b0);
    host.xfer(ap, rd, a, wd, bad, ack, rdat, rpar);
    check("ack", {29'h0, ack}, {29'h0, xa});
  endtask : go
  task automatic rd(input logic ap, input logic [1:0] a, input logic [2:0] xa,
                    input logic [31:0] xd);
    go(ap, 1'b1, a, '0, xa);
    if (xa === ACK_OK) begin
      check("rdata", rdat, xd);
      check("rparity", {31'h0, rpar}, {31'h0, ^xd});
    end
  endtask : rd
  task automatic wait_idle();
    for (int n = 0; n < 4000 && ap_busy; n++) @(posedge clk);
    if (ap_busy) begin
      errors++;
      tally_and_finish();
    end
  endtask : wait_idle

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic s_ident();
    host.line_reset();
    rd(0, DPRL_A_IDENT, ACK_OK, {DPRL_PORT_ID[31:16], DPRL_ARCH_VERSION, DPRL_PORT_ID[11:0]});
  endtask : s_ident
  task automatic s_data_link_control();
    go(0, 0, DPRL_A_SELECT, 32'h0000_0001, ACK_OK);
    go(0, 0, DPRL_A_CTRL, 32'hffff_ffff, ACK_OK);
    rd(0, DPRL_A_CTRL, ACK_OK, 32'h0000_0340);
    go(0, 0, DPRL_A_SELECT, 32'h0000_0000, ACK_OK);
  endtask : s_data_link_control
  task automatic s_proto();
    go(0, 0, DPRL_A_CTRL, 32'h0000_0001, ACK_OK);
    go(0, 1, DPRL_A_IDENT, '0, 3'h7, 1'b1);
    go(0, 1, DPRL_A_IDENT, '0, 3'h7);
    host.line_reset();
    rd(0, DPRL_A_CTRL, ACK_OK, 32'h0000_0003);
    go(0, 0, DPRL_A_IDENT, 32'h0000_0010, ACK_OK);
  endtask : s_proto
  task automatic s_orun();
    ap_lat = 1500;
    go(1, 1, 2'h0, '0, ACK_OK);
    go(1, 1, 2'h0, '0, ACK_WAIT);
    go(1, 1, 2'h0, '0, ACK_FAULT);
    go(0, 0, DPRL_A_CTRL, 32'h0000_0001, ACK_FAULT);
    rd(0, DPRL_A_CTRL, ACK_OK, 32'h0000_0003);
    go(0, 0, DPRL_A_SELECT, 32'h0000_0001, ACK_OK);
    go(0, 1, DPRL_A_CTRL, '0, ACK_FAULT);
    go(0, 0, DPRL_A_IDENT, 32'h0000_0010, ACK_OK);
    wait_idle();
  endtask : s_orun
  task automatic s_data_link_control_wait();
    go(0, 0, DPRL_A_SELECT, 32'h0000_0000, ACK_OK);
    go(0, 0, DPRL_A_CTRL, 32'h0000_0000, ACK_OK);
    go(0, 0, DPRL_A_SELECT, 32'h0000_0001, ACK_OK);
    go(1, 1, 2'h1, '0, ACK_OK);
    go(0, 1, DPRL_A_CTRL, '0, ACK_WAIT);
    wait_idle();
    rd(0, DPRL_A_CTRL, ACK_OK, 32'h0000_0340);
    go(0, 0, DPRL_A_SELECT, 32'h0000_0000, ACK_OK);
  endtask : s_data_link_control_wait
  task automatic s_posted();
    ap_lat = 2;
    go(1, 1, 2'h1, '0, ACK_OK);
    go(0, 1, DPRL_A_IDENT, '0, ACK_OK);
    rd(0, DPRL_A_RDBUF, ACK_OK, last_rd);
    go(1, 1, 2'h2, '0, ACK_OK);
    go(0, 0, DPRL_A_SELECT, 32'h0000_0000, ACK_OK);
    rd(0, DPRL_A_RDBUF, ACK_OK, 32'h0000_0000);
  endtask : s_posted
  task automatic s_apside();
    int n0;
    go(0, 0, DPRL_A_SELECT, 32'h0300_0020, ACK_OK);
    go(0, 0, DPRL_A_CTRL, 32'h0000_5004, ACK_OK);
    check("trn_count", {20'h0, ap_trn_count}, 32'h0000_0005);
    check("trn_mode", {30'h0, ap_trn_mode}, 32'h0000_0001);
    go(1, 0, 2'h1, 32'h1234_5678, ACK_OK);
    check("ap_write", {31'h0, cap[48]}, 32'h0000_0001);
    check("ap_sel", {24'h0, cap[47:40]}, 32'h0000_0003);
    check("ap_addr", {24'h0, cap[39:32]}, 32'h0000_0024);
    check("ap_wdata", cap[31:0], 32'h1234_5678);
    @(posedge clk);
    #DLY ap_cmp_fail = 1'b1;
    go(1, 1, 2'h0, '0, ACK_OK);
    rd(0, DPRL_A_CTRL, ACK_OK, 32'h0000_5014);
    @(posedge clk);
    #DLY ap_cmp_fail = 1'b0;
    ap_present = 1'b0;
    go(0, 0, DPRL_A_IDENT, 32'h0000_0003, ACK_OK);
    check("aborts", n_abort, 32'h0000_0001);
    n0 = ap_n;
    go(1, 1, 2'h0, '0, ACK_OK);
    rd(0, DPRL_A_RDBUF, ACK_OK, 32'h0000_0000);
    check("ap_count", ap_n, n0);
    @(posedge clk);
    #DLY ap_present = 1'b1;
    go(0, 0, DPRL_A_CTRL, 32'h0000_0000, ACK_OK);
  endtask : s_apside

  // Guards against a hang anywhere in the run
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    tally_and_finish();
  end
  initial begin
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    #DLY rst_n = 1'b1;
    s_ident();
    s_data_link_control();
    s_proto();
    s_orun();
    s_data_link_control_wait();
    s_posted();
    s_apside();
    tally_and_finish();
  end
endmodule : dprl_port_tb
